// ===== rtl/link_status_pkg.sv
// package of constants and types for the internal link state report register
// Summary of operation
// - the four-bit speed field in bits 3:0 reports an index where code 1 points at vector bit 0 up to code 7 for bit 6.
// - speed codes outside 1..7 are never reported, and the field has no meaning while the link is down.
// - without live speed reporting the speed field shows a fixed constant.
// - the six-bit width field in bits 9:4 reports lanes as 1,2,4,8,12,16,32 with their codes, never a reserved code.
// - without live width reporting the width field shows a fixed constant.
`default_nettype none
package link_status_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] link_state_index = 12'h00a; // register index, not word aligned
	localparam logic [11:0] link_state_addr = 12'h028; // byte address = index times four
	localparam int speed_lsb = 0;
	localparam int speed_msb = 3;
	localparam int width_lsb = 4;
	localparam int width_msb = 9;

	// ----------------------------------------
	// encodings
	// ----------------------------------------
	localparam logic [3:0] speed_min = 4'h1;
	localparam logic [3:0] speed_max = 4'h7;
	localparam logic [3:0] speed_fixed = 4'h1;
	localparam logic [5:0] width_x1 = 6'h01;
	localparam logic [5:0] width_x2 = 6'h02;
	localparam logic [5:0] width_x4 = 6'h04;
	localparam logic [5:0] width_x8 = 6'h08;
	localparam logic [5:0] width_x12 = 6'h0c;
	localparam logic [5:0] width_x16 = 6'h10;
	localparam logic [5:0] width_x32 = 6'h20;
	localparam logic [5:0] width_fixed = 6'h01;
	localparam logic [31:0] reset_value = 32'h0000_0000;

	// link state as handed in by training logic
	typedef struct packed {
		logic up;
		logic [3:0] speed;
		logic [5:0] width;
	} link_state_t;

	typedef enum logic [0:0] {
		acc_idle = 1'b0,
		acc_busy = 1'b1
	} acc_state_t;

endpackage
`default_nettype wire

// ===== rtl/root_link_status_reg.sv
// apb slave presenting the internal link state report register
`timescale 1ns/1ps
`default_nettype none
module root_link_status_reg #(
	parameter bit live_speed = 1'b1,
	parameter bit live_width = 1'b1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire link_status_pkg::link_state_t link_in
);
	import link_status_pkg::*;

	// ----------------------------------------
	// validity checks on training inputs
	// ----------------------------------------
	function automatic logic width_ok(input logic [5:0] w);
		case (w)
			width_x1, width_x2, width_x4, width_x8, width_x12, width_x16, width_x32: width_ok = 1'b1;
			default: width_ok = 1'b0;
		endcase
	endfunction

	function automatic logic speed_ok(input logic [3:0] s);
		speed_ok = (s >= speed_min) && (s <= speed_max);
	endfunction

	// ----------------------------------------
	// address and read word
	// ----------------------------------------
	// address decode, shared by the error flag and the read path
	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == link_state_addr);
	endfunction

	// places both fields in the read word, the upper bits stay zero
	function automatic logic [31:0] pack_report(input logic [3:0] s, input logic [5:0] w);
		pack_report = reset_value;
		pack_report[speed_msb:speed_lsb] = s;
		pack_report[width_msb:width_lsb] = w;
	endfunction

	// ----------------------------------------
	// registers and wires
	// ----------------------------------------
	link_state_t link_s1_q, link_s2_q, link_s3_q;
	logic link_steady;
	logic [3:0] speed_q;
	logic [5:0] width_q;
	acc_state_t st_q, st_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic access_start;
	logic read_hit;

	// ----------------------------------------
	// link state synchroniser
	// ----------------------------------------
	// two flops against metastability, a third keeps the word of the edge before
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			link_s1_q <= '0;
			link_s2_q <= '0;
			link_s3_q <= '0;
		end else begin
			link_s1_q <= link_in;
			link_s2_q <= link_s1_q;
			link_s3_q <= link_s2_q;
		end
	end

	// the bits of one update may cross on different edges, so a word counts only
	// once it has been seen on two edges in a row, and only while the link is up
	assign link_steady = (link_s2_q == link_s3_q) && link_s2_q.up;

	// ----------------------------------------
	// current speed field
	// ----------------------------------------
	generate
		if (live_speed) begin : g_speed_live
			logic [3:0] speed_d;
			// a legal code of an up link is taken, anything else keeps the last one
			always_comb begin
				speed_d = speed_q;
				if (link_steady && speed_ok(link_s2_q.speed)) begin
					speed_d = link_s2_q.speed;
				end
			end

			// field register, no path from the bus reaches it
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					speed_q <= speed_fixed;
				end else begin
					speed_q <= speed_d;
				end
			end
		end else begin : g_speed_fixed
			// no live reporting on this link: the field is a constant
			assign speed_q = speed_fixed;
		end
	endgenerate

	// ----------------------------------------
	// negotiated width field
	// ----------------------------------------
	generate
		if (live_width) begin : g_width_live
			logic [5:0] width_d;
			// a legal lane code of an up link is taken, anything else keeps the last one
			always_comb begin
				width_d = width_q;
				if (link_steady && width_ok(link_s2_q.width)) begin
					width_d = link_s2_q.width;
				end
			end

			// field register, no path from the bus reaches it
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					width_q <= width_fixed;
				end else begin
					width_q <= width_d;
				end
			end
		end else begin : g_width_fixed
			// no live reporting on this link: the field is a constant
			assign width_q = width_fixed;
		end
	endgenerate

	// ----------------------------------------
	// apb access sequencing
	// ----------------------------------------
	// an access is taken in its first access cycle and answered in the next
	assign access_start = psel && penable && (st_q == acc_idle);
	// only a read of the mapped word returns the fields, writes change nothing
	assign read_hit = access_start && !pwrite && addr_hit(paddr);
	// pwdata and pstrb are accepted and dropped: both fields are read-only

	// next state: idle, then one busy cycle that carries pready
	always_comb begin
		st_d = st_q;
		case (st_q)
			acc_idle: begin
				if (access_start) begin
					st_d = acc_busy;
				end
			end
			acc_busy: begin
				st_d = acc_idle;
			end
			default: begin
				st_d = acc_idle;
			end
		endcase
	end

	// access state register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q <= acc_idle;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// read data and error
	// ----------------------------------------
	// read word is loaded as an access is taken and held until the next one
	always_comb begin
		rdata_d = rdata_q;
		if (read_hit) begin
			rdata_d = pack_report(speed_q, width_q);
		end else if (access_start) begin
			rdata_d = reset_value; // writes and unmapped reads return zero
		end
	end

	// read data register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_q <= reset_value;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// error flag: set for an unmapped address, kept through the busy cycle
	always_comb begin
		err_d = 1'b0;
		if (access_start) begin
			err_d = !addr_hit(paddr);
		end else if (st_q == acc_busy) begin
			err_d = err_q;
		end
	end

	// error register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			err_q <= 1'b0;
		end else begin
			err_q <= err_d;
		end
	end

	// ----------------------------------------
	// bus outputs
	// ----------------------------------------
	// ready decodes from the state, error is its register gated by ready, read data comes from its register
	assign pready = (st_q == acc_busy);
	assign pslverr = pready && err_q;
	assign prdata = rdata_q;

endmodule
`default_nettype wire

// ===== tb/rls_checker.sv
// port assertions for the link status register
`timescale 1ns/1ps
`default_nettype none
module rls_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// legal field codes on every good read answer
	chk_speed_code: assert property (pready && !pslverr && !pwrite |->
		prdata[3:0] inside {[4'h1:4'h7]})
		else $error("speed code out of range");
	chk_width_code: assert property (pready && !pslverr && !pwrite |->
		prdata[9:4] inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20})
		else $error("width code reserved");
	// bus timing and refusal
	chk_bad_addr: assert property (pready |-> pslverr == (paddr != 12'h028))
		else $error("error flag wrong");
	chk_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("answer late");
	chk_pulse_len: assert property (pready |=> !pready)
		else $error("ready too long");
	chk_hold_idle: assert property (!psel |=> $stable(prdata))
		else $error("read data moved");
	chk_upper_zero: assert property (pready |-> prdata[31:10] == 22'h00_0000)
		else $error("upper read bits set");
endmodule
bind root_link_status_reg rls_checker chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.prdata(prdata));
`default_nettype wire

// ===== tb/root_link_status_reg_bench.sv
// bench for the link status register
`timescale 1ns/1ps
`default_nettype none
module root_link_status_reg_bench;
	import link_status_pkg::*;
	logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] prdata, rd;
	logic pready_fx, pslverr_fx, er_fx;
	logic [31:0] prdata_fx, rd_fx;
	logic [5:0] wt [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};
	link_state_t link_in = '0;
	int num_errors = 0, comparisons = 0, cyc = 0;
	root_link_status_reg dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(32'hffff_ffff), .pstrb(4'hf), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .link_in(link_in));
	// second copy with both fields hardwired
	root_link_status_reg #(.live_speed(1'b0), .live_width(1'b0)) dut_fixed (.clk_sys(clk_sys),
		.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(32'hffff_ffff), .pstrb(4'hf), .pready(pready_fx), .pslverr(pslverr_fx),
		.prdata(prdata_fx), .link_in(link_in));
	// clock and hang limit
	initial forever #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cyc == 2000) begin
		num_errors++;
		print_verdict;
	end
	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [11:0] a);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		@(posedge clk_sys) penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1 || pready_fx !== 1'b1);
		rd = prdata;
		er = pslverr;
		rd_fx = prdata_fx;
		er_fx = pslverr_fx;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic check(input logic [31:0] exp, input logic ee);
		logic [31:0] exp_fx;
		exp_fx = ee ? 32'h0000_0000 : {22'h00_0000, width_fixed, speed_fixed};
		comparisons++;
		if (rd !== exp || er !== ee) begin
			num_errors++;
			$display("mismatch at %0t: read %h err %b", $time, rd, er);
		end
		comparisons++;
		if (rd_fx !== exp_fx || er_fx !== ee) begin
			num_errors++;
			$display("mismatch at %0t: fixed read %h err %b", $time, rd_fx, er_fx);
		end
	endtask
	// drive the link state, let it settle, read back
	task automatic lnk(input logic u, input logic [3:0] s, input logic [5:0] w,
		input logic [3:0] es, input logic [5:0] ew);
		link_in <= '{u, s, w};
		repeat (4) @(posedge clk_sys);
		apb(1'b0, 12'h028);
		check({22'h00_0000, ew, es}, 1'b0);
	endtask
	task automatic t_reset;
		apb(1'b0, 12'h028);
		check({22'h00_0000, width_fixed, speed_fixed}, 1'b0);
		apb(1'b1, 12'h028);
		apb(1'b0, 12'h028);
		check({22'h00_0000, width_fixed, speed_fixed}, 1'b0);
		apb(1'b0, 12'h02c);
		check(32'h0000_0000, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_codes;
		for (int i = 1; i < 8; i++) lnk(1'b1, 4'(i), wt[i-1], 4'(i), wt[i-1]);
		$display("test codes done");
	endtask
	task automatic t_hold;
		lnk(1'b1, 4'h8, 6'h03, 4'h7, 6'h20);
		lnk(1'b0, 4'h2, 6'h02, 4'h7, 6'h20);
		$display("test hold done");
	endtask
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset;
		t_codes;
		t_hold;
		print_verdict;
	end
endmodule
`default_nettype wire
